/* File: hw/lapt_pkg.sv */
// Purpose: constants and types for the light converter power/timing control
// Assumes: core clock of 25 MHz, register access from the serial link domain
// Notes: offsets are the register indices seen on the link address field
//
// How it works
// - control bit 0 powers device up/down
// - control bit 1 starts/stops both channels
// - timing register steps integration by 2.7 ms
// - timing register resets to zero, manual mode
// - codes 00011 start, 00010 stop manual integration
package lapt_pkg;

  // register indices and special-function codes on the link address field
  localparam logic [4:0] OFS_CONTROL = 5'h00;
  localparam logic [4:0] OFS_TIMING = 5'h01;
  localparam logic [4:0] SF_STOP = 5'h02;
  localparam logic [4:0] SF_START = 5'h03;

  // control register field positions
  localparam int BIT_POWER = 0;
  localparam int BIT_ENABLE = 1;
  localparam int BIT_VALID = 4;
  localparam int BIT_INTR = 5;

  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] TIMING_RST = 8'h00;

  // one integration interval, in ns, and the core clock period
  localparam int INTERVAL_NS = 2700000;
  localparam int CLOCK_NS = 40;
  localparam int INTERVAL_CYC = INTERVAL_NS / CLOCK_NS;

  // integration engine states
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_AUTO = 2'b01,
    ST_MAN_WAIT = 2'b10,
    ST_MAN_RUN = 2'b11
  } lapt_state_t;

endpackage

/* File: hw/lapt_ctrl.sv */
// Purpose: power, enable and integration timing control of the converter
// Assumes: link strobes are synchronous to LINK_CLK; INTR_IN is core logic
// Notes: registers live in the link domain, the core copies them on a toggle
module lapt_ctrl
  import lapt_pkg::*;
#(
  parameter int INTERVAL_CYCLES = INTERVAL_CYC,
  parameter int TICK_W = 17
) (
  // core clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // serial link register port
  input wire logic LINK_CLK,
  input wire logic LINK_WR,
  input wire logic LINK_CMD,
  input wire logic [4:0] LINK_ADDR,
  input wire logic [7:0] LINK_WDATA,
  output logic [7:0] LINK_RDATA,
  // interrupt state from the threshold logic
  input wire logic INTR_IN,
  // converter control outputs
  output logic POWERED,
  output logic INTEGRATING,
  output logic INTEG_DONE,
  output logic CONV_VALID,
  output logic [15:0] MANUAL_INTERVALS
);

  // refuse interval counts the tick counter cannot hold
  if (INTERVAL_CYCLES < 2 || INTERVAL_CYCLES > (1 << TICK_W)) begin : g_chk
    $error("INTERVAL_CYCLES out of range for TICK_W");
  end

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(INTERVAL_CYCLES - 1);

  //////////////////////////////////////////////////////////////////////////
  // link domain: reset crossing, registers, toggles, readback
  //////////////////////////////////////////////////////////////////////////

  logic lrst_s1, lrst_s2; // core reset brought onto the link clock
  logic lrst_n; // link-side synchronous reset, active low
  logic [1:0] ctrl_q, ctrl_d; // power and enable bits
  logic [7:0] timing_q, timing_d; // integration_period_setting
  logic [2:0] ltgl_q, ltgl_d; // write, start, stop event toggles
  logic [1:0] stat_s1, stat_s2; // valid and interrupt levels, synced
  logic valid_q, valid_d; // completed-cycle flag, core clock
  logic [7:0] rdata_d; // next readback byte

  // reset sync: needs a few link edges while RST_N is low, which frames sent after reset do not supply
  always_ff @(posedge LINK_CLK) begin
    lrst_s1 <= RST_N;
    lrst_s2 <= lrst_s1;
  end
  assign lrst_n = lrst_s2;

  // register writes and special-function commands
  always_comb begin
    ctrl_d = ctrl_q;
    timing_d = timing_q;
    ltgl_d = ltgl_q;
    if (LINK_WR) begin
      // reserved control bits are dropped and read back as zero
      if (LINK_ADDR == OFS_CONTROL) begin
        ctrl_d = LINK_WDATA[1:0];
        ltgl_d[0] = ~ltgl_q[0];
      end else if (LINK_ADDR == OFS_TIMING) begin
        timing_d = LINK_WDATA;
        ltgl_d[0] = ~ltgl_q[0];
      end
    end else if (LINK_CMD) begin
      // start and stop only act in manual mode, decided in the core
      if (LINK_ADDR == SF_START) begin
        ltgl_d[1] = ~ltgl_q[1];
      end else if (LINK_ADDR == SF_STOP) begin
        ltgl_d[2] = ~ltgl_q[2];
      end
    end
  end

  // register the link-side state
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      ctrl_q <= CONTROL_RST[1:0];
      timing_q <= TIMING_RST;
      ltgl_q <= 3'h0;
    end else begin
      ctrl_q <= ctrl_d;
      timing_q <= timing_d;
      ltgl_q <= ltgl_d;
    end
  end

  // status levels crossing into the link domain
  always_ff @(posedge LINK_CLK) begin
    stat_s1 <= {INTR_IN, valid_q};
    stat_s2 <= stat_s1;
  end

  // readback; unmapped addresses return zero
  always_comb begin
    rdata_d = 8'h00;
    if (LINK_ADDR == OFS_CONTROL) begin
      rdata_d[BIT_POWER] = ctrl_q[0];
      rdata_d[BIT_ENABLE] = ctrl_q[1];
      rdata_d[BIT_VALID] = stat_s2[0];
      rdata_d[BIT_INTR] = stat_s2[1];
    end else if (LINK_ADDR == OFS_TIMING) begin
      rdata_d = timing_q;
    end
  end

  // readback byte is registered, valid one link edge after the address
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      LINK_RDATA <= 8'h00;
    end else begin
      LINK_RDATA <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // crossing of link events into the core
  //////////////////////////////////////////////////////////////////////////

  logic [2:0] tg_s1, tg_s2, tg_s3; // toggle synchronisers and history
  logic [2:0] tg_ev; // one-cycle core events
  logic wr_ev, start_ev, stop_ev;
  logic pow_q, pow_d, en_q, en_d; // core copies of control bits
  logic [7:0] tim_q, tim_d; // core copy of the timing byte

  // the link registers change on the same link edge as the toggle, two core edges before its event
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      tg_s1 <= 3'h0;
      tg_s2 <= 3'h0;
      tg_s3 <= 3'h0;
    end else begin
      tg_s1 <= ltgl_q;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
    end
  end
  assign tg_ev = tg_s2 ^ tg_s3;
  assign wr_ev = tg_ev[0];
  assign start_ev = tg_ev[1];
  assign stop_ev = tg_ev[2];

  // copy the configuration on each write event
  always_comb begin
    pow_d = pow_q;
    en_d = en_q;
    tim_d = tim_q;
    if (wr_ev) begin
      pow_d = ctrl_q[0];
      en_d = ctrl_q[1];
      tim_d = timing_q;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      pow_q <= 1'b0;
      en_q <= 1'b0;
      tim_q <= TIMING_RST;
    end else begin
      pow_q <= pow_d;
      en_q <= en_d;
      tim_q <= tim_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // integration engine
  //////////////////////////////////////////////////////////////////////////

  lapt_state_t st_q, st_d; // engine state
  logic [TICK_W-1:0] tick_q, tick_d; // cycles within one interval
  logic [7:0] intv_q, intv_d; // integration_interval_count so far
  logic [15:0] man_q, man_d; // intervals elapsed in manual run
  logic done_q, done_d; // one-cycle completion pulse
  logic run; // both power and enable asserted
  logic manual; // timing byte of zero
  logic tick_last; // last cycle of an interval
  logic [7:0] target; // intervals per automatic cycle

  assign run = pow_q & en_q;
  assign manual = (tim_q == 8'h00);
  assign tick_last = (tick_q == TICK_LAST);
  assign target = 8'(~tim_q + 8'h01);

  // next-state logic; a timing change takes effect at once
  always_comb begin
    st_d = st_q;
    tick_d = tick_q;
    intv_d = intv_q;
    man_d = man_q;
    valid_d = valid_q;
    done_d = 1'b0;
    if (!run) begin
      // power or enable low: both channels held off, flag dropped
      st_d = ST_OFF;
      tick_d = '0;
      intv_d = 8'h00;
      valid_d = 1'b0;
    end else begin
      case (st_q)
        ST_OFF: begin
          st_d = manual ? ST_MAN_WAIT : ST_AUTO;
          tick_d = '0;
          intv_d = 8'h00;
        end
        ST_AUTO: begin
          if (manual) begin
            st_d = ST_MAN_WAIT;
          end else if (tick_last) begin
            tick_d = '0;
            // cycle ends after target intervals, then restarts
            if (intv_q >= 8'(target - 8'h01)) begin
              intv_d = 8'h00;
              done_d = 1'b1;
              valid_d = 1'b1;
            end else begin
              intv_d = 8'(intv_q + 8'h01);
            end
          end else begin
            tick_d = TICK_W'(tick_q + 1'b1);
          end
        end
        ST_MAN_WAIT: begin
          if (!manual) begin
            st_d = ST_AUTO;
            tick_d = '0;
            intv_d = 8'h00;
          end else if (start_ev) begin
            st_d = ST_MAN_RUN;
            tick_d = '0;
            man_d = 16'h0000;
          end
        end
        ST_MAN_RUN: begin
          if (!manual) begin
            st_d = ST_AUTO;
            tick_d = '0;
            intv_d = 8'h00;
          end else if (stop_ev) begin
            st_d = ST_MAN_WAIT;
            done_d = 1'b1;
            valid_d = 1'b1;
          end else if (tick_last) begin
            tick_d = '0;
            // saturate rather than wrap on very long manual runs
            if (man_q != 16'hFFFF) begin
              man_d = 16'(man_q + 16'h0001);
            end
          end else begin
            tick_d = TICK_W'(tick_q + 1'b1);
          end
        end
        default: st_d = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      st_q <= ST_OFF;
      tick_q <= '0;
      intv_q <= 8'h00;
      man_q <= 16'h0000;
      valid_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tick_q <= tick_d;
      intv_q <= intv_d;
      man_q <= man_d;
      valid_q <= valid_d;
      done_q <= done_d;
    end
  end

  // outputs
  assign POWERED = pow_q;
  assign INTEGRATING = (st_q == ST_AUTO) || (st_q == ST_MAN_RUN);
  assign INTEG_DONE = done_q;
  assign CONV_VALID = valid_q;
  assign MANUAL_INTERVALS = man_q;

  //////////////////////////////////////////////////////////////////////////
  // assertions
  //////////////////////////////////////////////////////////////////////////

  sequence s_man_start;
    run && manual && st_q == ST_MAN_WAIT && start_ev;
  endsequence

  sequence s_man_stop;
    run && manual && st_q == ST_MAN_RUN && stop_ev;
  endsequence

  property p_power_off;
    @(posedge CLOCK) disable iff (!RST_N)
      !pow_q |=> st_q == ST_OFF && !INTEGRATING;
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("engine active while powered down");

  property p_enable_off;
    @(posedge CLOCK) disable iff (!RST_N)
      (pow_q && !en_q) |=> !CONV_VALID && !INTEG_DONE;
  endproperty
  a_enable_off: assert property (p_enable_off)
    else $error("converter active while disabled");

  property p_done_valid;
    @(posedge CLOCK) disable iff (!RST_N)
      INTEG_DONE |-> CONV_VALID;
  endproperty
  a_done_valid: assert property (p_done_valid)
    else $error("completion without valid flag");

  property p_intr_read;
    @(posedge LINK_CLK) disable iff (!lrst_n)
      LINK_ADDR == OFS_CONTROL |=> LINK_RDATA[BIT_INTR] == $past(stat_s2[1]);
  endproperty
  a_intr_read: assert property (p_intr_read)
    else $error("interrupt flag readback wrong");

  property p_tick_range;
    @(posedge CLOCK) disable iff (!RST_N)
      tick_q <= TICK_LAST;
  endproperty
  a_tick_range: assert property (p_tick_range)
    else $error("interval counter overran");

  property p_timing_reset;
    @(posedge CLOCK) !RST_N |=> tim_q == 8'h00 && st_q == ST_OFF;
  endproperty
  a_timing_reset: assert property (p_timing_reset)
    else $error("timing copy not zero after reset");

  property p_auto_end;
    @(posedge CLOCK) disable iff (!RST_N)
      (run && !manual && st_q == ST_AUTO && tick_last &&
       intv_q == 8'(target - 8'h01)) |=> INTEG_DONE ##1 !INTEG_DONE;
  endproperty
  a_auto_end: assert property (p_auto_end)
    else $error("automatic cycle did not end on count");

  property p_manual_quiet;
    @(posedge CLOCK) disable iff (!RST_N)
      (run && manual && st_q == ST_MAN_WAIT) |=> !INTEG_DONE;
  endproperty
  a_manual_quiet: assert property (p_manual_quiet)
    else $error("manual mode completed without stop");

  property p_man_seq;
    @(posedge CLOCK) disable iff (!RST_N)
      s_man_start |=> st_q == ST_MAN_RUN && man_q == 16'h0000;
  endproperty
  a_man_seq: assert property (p_man_seq)
    else $error("manual start not taken");

  property p_man_stop;
    @(posedge CLOCK) disable iff (!RST_N)
      s_man_stop |=> INTEG_DONE && st_q == ST_MAN_WAIT;
  endproperty
  a_man_stop: assert property (p_man_stop)
    else $error("manual stop not taken");

endmodule

/* File: tb/lapt_host.sv */
// Purpose: host model driving the link register port
// Assumes: link clock of 12 ns, standing low between frames
// Notes: released data shows a changing pattern, not the last byte
module lapt_host (
  // link pins toward the device
  output logic lclk,
  output logic wr,
  output logic cmd,
  output logic [4:0] addr,
  output logic [7:0] wdata,
  // readback from the device
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////
  // idle levels at time zero
  initial begin
    lclk = 1'b0;
    wr = 1'b0;
    cmd = 1'b0;
    addr = 5'h1F;
    wdata = 8'hA5;
  end

  // clock edges; strobes drop and data toggles just after each rise
  task lpulse(input int n);
    repeat (n) begin
      lclk = 1'b1;
      #1 wr = 1'b0;
      cmd = 1'b0;
      wdata = ~wdata;
      #5 lclk = 1'b0;
      #6;
    end
  endtask

  // one frame: lead edge, request held to the take edge, then flush
  task xfer(input logic w, input logic c, input logic [4:0] a,
            input logic [7:0] d);
    lclk = 1'b1;
    #1 addr = a;
    wdata = d;
    wr = w;
    cmd = c;
    #5 lclk = 1'b0;
    #6;
    lpulse(3);
  endtask
endmodule

/* File: tb/tb_light_adc_power_timing_ctrl.sv */
// Purpose: self-checking bench of the power and timing control
// Assumes: shortened interval of 8 core cycles
// Notes: one real 2 ms wait after power-up dominates the run
module tb_light_adc_power_timing_ctrl import lapt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IC = 8; // short interval keeps the run small
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic intr_in = 1'b0;
  logic lclk, lwr, lcmd, powered, integ, done, valid;
  logic [4:0] laddr;
  logic [7:0] lwdata, lrdata, t, e;
  logic [15:0] man;
  logic [31:0] seed = 32'hDD0C1AE1;
  int fails = 0;
  int num_checks = 0;
  int n;

  ////////////////////////////////////////////////////////////////
  always #20 clock = ~clock;

  lapt_ctrl #(.INTERVAL_CYCLES(IC), .TICK_W(17)) uut (
    .CLOCK(clock), .RST_N(rst_n), .LINK_CLK(lclk), .LINK_WR(lwr),
    .LINK_CMD(lcmd), .LINK_ADDR(laddr), .LINK_WDATA(lwdata),
    .LINK_RDATA(lrdata), .INTR_IN(intr_in), .POWERED(powered),
    .INTEGRATING(integ), .INTEG_DONE(done), .CONV_VALID(valid),
    .MANUAL_INTERVALS(man));

  lapt_host host (.lclk(lclk), .wr(lwr), .cmd(lcmd), .addr(laddr),
    .wdata(lwdata), .rdata(lrdata));

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task chk(input string what, input logic [15:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge clock);
    #2;
  endtask

  // register read through the link
  task creg(input logic [4:0] a, input logic [7:0] x, input string w);
    host.xfer(1'b0, 1'b0, a, 8'h00);
    chk(w, {8'h00, x}, {8'h00, lrdata});
  endtask

  // writes are spaced so the core copy sees each one
  task wr(input logic [4:0] a, input logic [7:0] d);
    host.xfer(1'b1, 1'b0, a, d);
    cyc(8);
  endtask

  // bounded wait for a completion pulse, counting core cycles
  task wd(output int k);
    k = 0;
    do begin
      @(posedge clock);
      #1 k++;
    end while (done !== 1'b1 && k < 4000);
  endtask

  task summarize;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // watchdog sized for the 2 ms wait plus a margin
  initial begin
    #3000000;
    fails++;
    summarize();
  end

  initial begin
    fork host.lpulse(8); join_none // link sync needs edges in reset
    repeat (12) @(posedge clock);
    #2 rst_n = 1'b1;
    host.lpulse(3);
    chk("powered", 0, powered);
    creg(OFS_CONTROL, CONTROL_RST, "control");
    creg(OFS_TIMING, TIMING_RST, "timing");
    creg(5'h1F, 8'h00, "unmapped");
    $display("test reset done");
    // power up with read-only bits written as ones, reserved as zero
    seed = lfsr(seed);
    @(posedge clock) #2 intr_in = seed[0];
    wr(OFS_CONTROL, 8'h31);
    chk("powered", 1, powered);
    creg(OFS_CONTROL, {2'b00, intr_in, 5'h01}, "ctl");
    #2000000;
    $display("test power done");
    // automatic timing: boundary FF, then a random short setting
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      t = i ? {4'hF, seed[3:0]} : 8'hFF;
      wr(OFS_TIMING, t);
      creg(OFS_TIMING, t, "timing");
      wr(OFS_CONTROL, 8'h03);
      wd(n);
      wd(n);
      chk("period", 16'((256 - t) * IC), 16'(n));
      chk("valid", 1, valid);
      chk("integ", 1, integ);
      e = {2'b00, intr_in, 5'h13};
      creg(OFS_CONTROL, e, "ctl");
      wr(OFS_CONTROL, 8'h01);
      chk("integ", 0, integ);
      chk("valid", 0, valid);
    end
    $display("test auto done");
    // manual mode: waits for start, counts until stop
    wr(OFS_TIMING, 8'h00);
    wr(OFS_CONTROL, 8'h03);
    chk("integ", 0, integ);
    host.xfer(1'b0, 1'b1, SF_START, 8'h00);
    cyc(8);
    chk("integ", 1, integ);
    cyc(3 * IC);
    host.xfer(1'b0, 1'b1, SF_STOP, 8'h00);
    wd(n);
    chk("stop done", 1, 16'(n < 12));
    chk("man range", 1, 16'(man >= 3 && man <= 7));
    cyc(2);
    chk("integ", 0, integ);
    $display("test manual done");
    summarize();
  end
endmodule
